/* File: hdl/phi_pkg.sv */
// Constants shared by the host side interface logic
package phi_pkg;

  // ****************************************
  // Clock rates and derived counts
  // ****************************************
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned MII100_HZ     = 25_000_000;
  localparam int unsigned MII10_HZ      = 2_500_000;
  localparam int unsigned REF_CLK_HZ    = 125_000_000;
  localparam int unsigned HALF100_CYC   = (CLK_HZ / (2 * MII100_HZ)) < 1 ? 1 : CLK_HZ / (2 * MII100_HZ);
  localparam int unsigned HALF10_CYC    = (CLK_HZ / (2 * MII10_HZ)) < 1 ? 1 : CLK_HZ / (2 * MII10_HZ);
  localparam int unsigned HALFREF_CYC   = (CLK_HZ / (2 * REF_CLK_HZ)) < 1 ? 1 : CLK_HZ / (2 * REF_CLK_HZ);
  localparam int unsigned BLINK_CYC     = 2_500_000;
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;

  // ****************************************
  // Straps and link speed codes
  // ****************************************
  localparam logic [3:0]  MODE_GMII_MII = 4'h1;
  localparam logic [1:0]  SPD_10        = 2'h0;
  localparam logic [1:0]  SPD_100       = 2'h1;
  localparam logic [1:0]  SPD_1000      = 2'h2;

  // ****************************************
  // Management frame
  // ****************************************
  localparam logic [5:0]  PREAMBLE_ONES = 6'h20;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [5:0]  DATA_BITS     = 6'h10;
  localparam logic [5:0]  ADDR_BITS     = 6'h05;
  localparam logic [5:0]  OP_BITS       = 6'h02;
  localparam logic [5:0]  TA_BITS       = 6'h02;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0]  REG_INT_EN_STAT  = 5'h1b;
  localparam logic [4:0]  REG_MISC_CTRL    = 5'h1f;
  localparam logic [15:0] INT_EN_STAT_RST  = 16'h0000;
  localparam logic [15:0] MISC_CTRL_RST    = 16'h0000;
  localparam int unsigned INT_POL_BIT      = 14;

  typedef enum logic [2:0] {
    PHI_MS_PRE,
    PHI_MS_START,
    PHI_MS_OP,
    PHI_MS_PHY,
    PHI_MS_REG,
    PHI_MS_TA,
    PHI_MS_DATA
  } phi_mgmt_state_t;

endpackage

/* File: hdl/phi_host_if.sv */
// Host side data, management, interrupt and indicator logic of the transceiver
`timescale 1ns/1ps
`default_nettype none

module phi_host_if
  import phi_pkg::*;
#(
  parameter int unsigned BLINK_DIV = BLINK_CYC
) (
  input  wire  logic       clk,
  input  wire  logic       resetn,
  input  wire  logic [3:0] host_mode_strap,
  input  wire  logic       ref_clock_out_strap,
  input  wire  logic [2:0] phy_addr_strap,
  input  wire  logic       indicator_style_strap,
  input  wire  logic       gtx_clk,
  input  wire  logic       tx_en,
  input  wire  logic [7:0] txd,
  input  wire  logic       tx_er,
  output logic             tx_clk,
  output logic             rx_clk,
  output logic             rx_dv,
  output logic [7:0]       rxd,
  output logic             rx_er,
  output logic             crs,
  output logic             col,
  output logic             ref_clock_out,
  input  wire  logic       mdc,
  input  wire  logic       mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  output logic             int_pin,
  output logic             indicator_a,
  output logic             indicator_b,
  input  wire  logic       link_up,
  input  wire  logic [1:0] link_speed,
  input  wire  logic       link_activity,
  input  wire  logic       core_rx_dv,
  input  wire  logic [7:0] core_rxd,
  input  wire  logic       core_rx_er,
  input  wire  logic       core_crs,
  input  wire  logic       core_col,
  input  wire  logic [7:0] int_event,
  output logic             core_tx_strobe,
  output logic             core_tx_en,
  output logic [7:0]       core_txd,
  output logic             core_tx_er,
  output logic             host_mode_active
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned SW = 22;
  logic [SW-1:0]   sync1_ff;
  logic [SW-1:0]   sync2_ff;
  logic            gtx_prev_ff;
  logic            mdc_prev_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      gtx_prev_ff <= 1'b0;
      mdc_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= {host_mode_strap, ref_clock_out_strap, phy_addr_strap, indicator_style_strap,
                      gtx_clk, tx_en, txd, tx_er, mdc, mdio_i};
      sync2_ff    <= sync1_ff;
      gtx_prev_ff <= sync2_ff[12];
      mdc_prev_ff <= sync2_ff[1];
    end
  end

  logic [3:0] s_mode;
  logic       s_ref_en;
  logic [2:0] s_phyad;
  logic       s_style;
  logic       s_gtx;
  logic       s_tx_en;
  logic [7:0] s_txd;
  logic       s_tx_er;
  logic       s_mdc;
  logic       s_mdio;
  assign {s_mode, s_ref_en, s_phyad, s_style, s_gtx, s_tx_en, s_txd, s_tx_er, s_mdc, s_mdio} = sync2_ff;

  // ****************************************
  // Strap latch
  // ****************************************
  logic [1:0] strap_cnt_ff;
  logic       strap_done_ff;
  logic       mode_ok_ff;
  logic       ref_en_ff;
  logic [2:0] phyad_ff;
  logic       style_single_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      strap_cnt_ff    <= '0;
      strap_done_ff   <= 1'b0;
      mode_ok_ff      <= 1'b0;
      ref_en_ff       <= 1'b0;
      phyad_ff        <= '0;
      style_single_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == STRAP_WAIT) begin
        strap_done_ff   <= 1'b1;
        mode_ok_ff      <= (s_mode == MODE_GMII_MII);
        ref_en_ff       <= s_ref_en;
        phyad_ff        <= s_phyad;
        style_single_ff <= s_style;
      end
    end
  end

  // ****************************************
  // Clock generation
  // ****************************************
  logic [4:0] mii_cnt_ff;
  logic       mii_clk_ff;
  logic [4:0] ref_cnt_ff;
  logic       ref_clk_ff;
  logic [4:0] half_cyc;
  logic       mii_rise;
  assign half_cyc = (link_speed == SPD_10) ? 5'(HALF10_CYC) : 5'(HALF100_CYC);
  assign mii_rise = mode_ok_ff && !mii_clk_ff && (mii_cnt_ff + 5'h1 >= half_cyc);

  always_ff @(posedge clk) begin
    if (!resetn || !mode_ok_ff) begin
      mii_cnt_ff <= '0;
      mii_clk_ff <= 1'b0;
    end else if (mii_cnt_ff + 5'h1 >= half_cyc) begin
      mii_cnt_ff <= '0;
      mii_clk_ff <= !mii_clk_ff;
    end else begin
      mii_cnt_ff <= mii_cnt_ff + 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !ref_en_ff) begin
      ref_cnt_ff <= '0;
      ref_clk_ff <= 1'b0;
    end else if (ref_cnt_ff + 5'h1 >= 5'(HALFREF_CYC)) begin
      ref_cnt_ff <= '0;
      ref_clk_ff <= !ref_clk_ff;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 5'h1;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  logic gig;
  logic tx_take;
  assign gig     = (link_speed == SPD_1000);
  assign tx_take = mode_ok_ff && (gig ? (s_gtx && !gtx_prev_ff) : mii_rise);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      core_tx_strobe <= 1'b0;
      core_tx_en     <= 1'b0;
      core_txd       <= '0;
      core_tx_er     <= 1'b0;
    end else begin
      core_tx_strobe <= tx_take;
      if (tx_take) begin
        core_tx_en <= s_tx_en;
        core_tx_er <= s_tx_er;
        core_txd   <= gig ? s_txd : {4'h0, s_txd[3:0]};
      end
    end
  end

  // ****************************************
  // Receive path and pin outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_clk           <= 1'b0;
      rx_clk           <= 1'b0;
      rx_dv            <= 1'b0;
      rxd              <= '0;
      rx_er            <= 1'b0;
      crs              <= 1'b0;
      col              <= 1'b0;
      ref_clock_out    <= 1'b0;
      host_mode_active <= 1'b0;
    end else begin
      tx_clk           <= mii_clk_ff && !gig;
      rx_clk           <= mii_clk_ff;
      ref_clock_out    <= ref_clk_ff;
      host_mode_active <= mode_ok_ff;
      crs              <= core_crs && mode_ok_ff;
      col              <= core_col && mode_ok_ff;
      if (mii_rise) begin
        rx_dv <= core_rx_dv;
        rx_er <= core_rx_er;
        rxd   <= gig ? core_rxd : {4'h0, core_rxd[3:0]};
      end
    end
  end

  // ****************************************
  // Management slave
  // ****************************************
  phi_mgmt_state_t ms_ff;
  logic [5:0]      bit_cnt_ff;
  logic [15:0]     shift_ff;
  logic            is_read_ff;
  logic            match_ff;
  logic [4:0]      reg_addr_ff;
  logic [15:0]     int_reg_ff;
  logic [15:0]     misc_ff;
  logic            mdc_rise;
  logic            rd_clear;
  logic            wr_int;
  logic            wr_misc;
  logic [15:0]     rd_data;
  logic [5:0]      nxt_cnt;
  logic [15:0]     nxt_shift;
  assign mdc_rise  = s_mdc && !mdc_prev_ff;
  assign nxt_cnt   = bit_cnt_ff + 6'h1;
  assign nxt_shift = {shift_ff[14:0], s_mdio};

  always_comb begin
    rd_data = '0;
    unique case (reg_addr_ff)
      REG_INT_EN_STAT: rd_data = int_reg_ff;
      REG_MISC_CTRL:   rd_data = misc_ff;
      default:         rd_data = '0;
    endcase
  end

  assign rd_clear = mdc_rise && (ms_ff == PHI_MS_TA) && (bit_cnt_ff == 6'h1) && is_read_ff && match_ff
                    && (reg_addr_ff == REG_INT_EN_STAT);
  assign wr_int   = mdc_rise && (ms_ff == PHI_MS_DATA) && (nxt_cnt == DATA_BITS) && !is_read_ff && match_ff
                    && (reg_addr_ff == REG_INT_EN_STAT);
  assign wr_misc  = mdc_rise && (ms_ff == PHI_MS_DATA) && (nxt_cnt == DATA_BITS) && !is_read_ff && match_ff
                    && (reg_addr_ff == REG_MISC_CTRL);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ms_ff       <= PHI_MS_PRE;
      bit_cnt_ff  <= '0;
      shift_ff    <= '0;
      is_read_ff  <= 1'b0;
      match_ff    <= 1'b0;
      reg_addr_ff <= '0;
      mdio_o      <= 1'b0;
      mdio_oe     <= 1'b0;
    end else if (mdc_rise) begin
      unique case (ms_ff)
        PHI_MS_PRE: begin
          mdio_oe <= 1'b0;
          if (s_mdio) begin
            bit_cnt_ff <= (bit_cnt_ff == PREAMBLE_ONES) ? bit_cnt_ff : nxt_cnt;
          end else begin
            bit_cnt_ff <= '0;
            if (bit_cnt_ff == PREAMBLE_ONES) ms_ff <= PHI_MS_START;
          end
        end
        PHI_MS_START: begin
          bit_cnt_ff <= '0;
          ms_ff      <= s_mdio ? PHI_MS_OP : PHI_MS_PRE;
        end
        PHI_MS_OP: begin
          shift_ff   <= nxt_shift;
          bit_cnt_ff <= nxt_cnt;
          if (nxt_cnt == OP_BITS) begin
            bit_cnt_ff <= '0;
            is_read_ff <= (nxt_shift[1:0] == OP_READ);
            ms_ff      <= (nxt_shift[1:0] == OP_READ || nxt_shift[1:0] == OP_WRITE) ? PHI_MS_PHY : PHI_MS_PRE;
          end
        end
        PHI_MS_PHY: begin
          shift_ff   <= nxt_shift;
          bit_cnt_ff <= nxt_cnt;
          if (nxt_cnt == ADDR_BITS) begin
            bit_cnt_ff <= '0;
            match_ff   <= (nxt_shift[4:0] == {2'b00, phyad_ff});
            ms_ff      <= PHI_MS_REG;
          end
        end
        PHI_MS_REG: begin
          shift_ff   <= nxt_shift;
          bit_cnt_ff <= nxt_cnt;
          if (nxt_cnt == ADDR_BITS) begin
            bit_cnt_ff  <= '0;
            reg_addr_ff <= nxt_shift[4:0];
            ms_ff       <= PHI_MS_TA;
          end
        end
        PHI_MS_TA: begin
          bit_cnt_ff <= nxt_cnt;
          if (is_read_ff && match_ff && bit_cnt_ff == 6'h0) begin
            mdio_oe <= 1'b1;
            mdio_o  <= 1'b0;
          end
          if (nxt_cnt == TA_BITS) begin
            bit_cnt_ff <= '0;
            ms_ff      <= PHI_MS_DATA;
            shift_ff   <= {rd_data[14:0], 1'b0};
            mdio_o     <= rd_data[15];
          end
        end
        PHI_MS_DATA: begin
          bit_cnt_ff <= nxt_cnt;
          if (is_read_ff) begin
            mdio_o   <= shift_ff[15];
            shift_ff <= {shift_ff[14:0], 1'b0};
          end else begin
            shift_ff <= nxt_shift;
          end
          if (nxt_cnt == DATA_BITS) begin
            bit_cnt_ff <= '0;
            mdio_oe    <= 1'b0;
            ms_ff      <= PHI_MS_PRE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt register and pin
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_reg_ff <= INT_EN_STAT_RST;
      misc_ff    <= MISC_CTRL_RST;
    end else begin
      if (wr_int) int_reg_ff[15:8] <= nxt_shift[15:8];
      if (wr_misc) misc_ff <= nxt_shift;
      int_reg_ff[7:0] <= (rd_clear ? 8'h00 : int_reg_ff[7:0]) | int_event;
    end
  end

  logic int_active;
  assign int_active = |(int_reg_ff[15:8] & int_reg_ff[7:0]);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_pin <= 1'b1;
    end else begin
      int_pin <= misc_ff[INT_POL_BIT] ? int_active : !int_active;
    end
  end

  // ****************************************
  // Link and activity indicators
  // ****************************************
  logic [31:0] blink_cnt_ff;
  logic        blink_ff;
  logic        act_lvl;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else if (blink_cnt_ff + 32'h1 >= 32'(BLINK_DIV)) begin
      blink_cnt_ff <= '0;
      blink_ff     <= !blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end

  assign act_lvl = link_activity ? blink_ff : 1'b0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      indicator_a <= 1'b1;
      indicator_b <= 1'b1;
    end else if (style_single_ff) begin
      indicator_b <= !link_up;
      indicator_a <= link_activity ? blink_ff : 1'b1;
    end else if (!link_up) begin
      indicator_a <= 1'b1;
      indicator_b <= 1'b1;
    end else begin
      unique case (link_speed)
        SPD_1000: begin
          indicator_b <= act_lvl;
          indicator_a <= 1'b1;
        end
        SPD_100: begin
          indicator_a <= act_lvl;
          indicator_b <= 1'b1;
        end
        default: begin
          indicator_a <= act_lvl;
          indicator_b <= act_lvl;
        end
      endcase
    end
  end

endmodule // phi_host_if

`default_nettype wire

/* File: test/phi_host_if_monitor.sv */
// Port level checker for the host side interface
`timescale 1ns/1ps
`default_nettype none

module phi_host_if_monitor
  import phi_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ref_clock_out_strap,
  input wire logic       indicator_style_strap,
  input wire logic       gtx_clk,
  input wire logic       tx_clk,
  input wire logic       rx_clk,
  input wire logic       rx_dv,
  input wire logic [7:0] rxd,
  input wire logic       rx_er,
  input wire logic       crs,
  input wire logic       core_crs,
  input wire logic       ref_clock_out,
  input wire logic       mdio_o,
  input wire logic       mdio_oe,
  input wire logic       int_pin,
  input wire logic       indicator_a,
  input wire logic       indicator_b,
  input wire logic       link_up,
  input wire logic [1:0] link_speed,
  input wire logic       core_tx_strobe,
  input wire logic       host_mode_active
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_rise_at(spd);
    $rose(rx_clk) && $past(link_speed, 2) == spd && $past(link_speed) == spd && link_speed == spd;
  endsequence
  sequence s_gtx_rise;
    $rose(gtx_clk) && host_mode_active && link_speed == SPD_1000;
  endsequence

  property p_reset_idle;
    disable iff (1'b0) !resetn |=> int_pin && indicator_a && indicator_b && !mdio_oe && !ref_clock_out;
  endproperty
  property p_ref;
    ref_clock_out |-> ref_clock_out_strap ##1 !ref_clock_out;
  endproperty
  property p_crs;
    host_mode_active && $past(host_mode_active) |-> crs == $past(core_crs);
  endproperty
  property p_rx_fast;
    s_rise_at(SPD_100) |=> !rx_clk;
  endproperty
  property p_rx_slow;
    s_rise_at(SPD_10) |-> rx_clk [*8];
  endproperty
  property p_nibble;
    s_rise_at(SPD_100) or s_rise_at(SPD_10) |-> rxd[7:4] == 4'h0;
  endproperty
  property p_rx_sync;
    $changed({rx_dv, rxd, rx_er}) |=> $rose(rx_clk);
  endproperty
  property p_tx_lat;
    s_gtx_rise |-> ##[2:5] core_tx_strobe;
  endproperty
  property p_ta;
    $rose(mdio_oe) |-> !mdio_o;
  endproperty
  property p_gig_txclk;
    $past(link_speed, 2) == SPD_1000 && $past(link_speed) == SPD_1000 |-> !tx_clk;
  endproperty
  property p_link_ind;
    host_mode_active && $past(host_mode_active, 2) && indicator_style_strap |-> indicator_b == !$past(link_up);
  endproperty
  property p_tri10;
    host_mode_active && $past(host_mode_active, 2) && !indicator_style_strap && $past(link_up)
      && $past(link_speed) == SPD_10 |-> indicator_a == indicator_b;
  endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
  a_ref: assert property (p_ref) else $error("reference clock wrong");
  a_crs: assert property (p_crs) else $error("carrier copy wrong");
  a_rx_fast: assert property (p_rx_fast) else $error("fast receive clock wrong");
  a_rx_slow: assert property (p_rx_slow) else $error("slow receive clock wrong");
  a_nibble: assert property (p_nibble) else $error("upper nibble driven");
  a_rx_sync: assert property (p_rx_sync) else $error("receive data off clock");
  a_tx_lat: assert property (p_tx_lat) else $error("transmit sample missing");
  a_ta: assert property (p_ta) else $error("turnaround not zero");
  a_gig_txclk: assert property (p_gig_txclk) else $error("transmit clock in gigabit");
  a_link_ind: assert property (p_link_ind) else $error("link indicator wrong");
  a_tri10: assert property (p_tri10) else $error("indicators not paired");
endmodule // phi_host_if_monitor

bind phi_host_if phi_host_if_monitor i_mon (
  .clk, .resetn, .ref_clock_out_strap, .indicator_style_strap, .gtx_clk, .tx_clk, .rx_clk, .rx_dv,
  .rxd, .rx_er, .crs, .core_crs, .ref_clock_out, .mdio_o, .mdio_oe, .int_pin, .indicator_a,
  .indicator_b, .link_up, .link_speed, .core_tx_strobe, .host_mode_active
);

`default_nettype wire

/* File: test/phi_mac_model.sv */
// Transmit side of the MAC partner
`timescale 1ns/1ps
`default_nettype none

module phi_mac_model (
  input  wire logic       run,
  input  wire logic       nibble,
  input  wire logic       tx_clk,
  output logic            gtx_clk,
  output logic            tx_en,
  output logic [7:0]      txd,
  output logic            tx_er
);
  // ****************************************
  // Clock and counting data
  // ****************************************
  logic       en_ff  = 1'b0;
  logic [7:0] cnt_ff = 8'h00;
  assign tx_en = en_ff;
  assign txd   = cnt_ff;
  assign tx_er = 1'b0;

  initial begin
    gtx_clk = 1'b0;
    forever begin
      #80;
      gtx_clk = run & ~nibble & ~gtx_clk;
    end
  end

  always @(negedge gtx_clk or posedge tx_clk) begin
    if (run) begin
      en_ff  <= 1'b1;
      cnt_ff <= (cnt_ff + 8'h01) & (nibble ? 8'h0f : 8'hff);
    end
  end
endmodule // phi_mac_model

`default_nettype wire

/* File: test/phi_host_if_tb.sv */
// Self-checking bench for the host side interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

module phi_host_if_tb;
  import phi_pkg::*;
  localparam logic [4:0] ME = 5'h05;
  logic       clk, resetn, ref_clock_out_strap, indicator_style_strap, mdc, host_oe, host_d, run;
  logic       link_up, link_activity, core_rx_dv, core_crs, b;
  logic [3:0] host_mode_strap;
  logic [1:0] link_speed;
  logic [7:0] core_rxd, int_event;
  logic [15:0] v;
  wire logic  gtx_clk, tx_en, tx_er, tx_clk, rx_clk, rx_dv, rx_er, crs, col, ref_clock_out, mdio_i;
  wire logic  mdio_o, mdio_oe, int_pin, indicator_a, indicator_b, core_tx_strobe, core_tx_en;
  wire logic  core_tx_er, host_mode_active;
  wire logic [7:0] txd, rxd, core_txd;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         n;

  // ****************************************
  // Design, partner and wire
  // ****************************************
  assign mdio_i = mdio_oe ? mdio_o : (host_oe ? host_d : 1'b1);
  phi_host_if #(.BLINK_DIV(8)) i_dut (
    .clk, .resetn, .host_mode_strap, .ref_clock_out_strap, .phy_addr_strap(3'h5), .indicator_style_strap,
    .gtx_clk, .tx_en, .txd, .tx_er, .tx_clk, .rx_clk, .rx_dv, .rxd, .rx_er, .crs, .col, .ref_clock_out,
    .mdc, .mdio_i, .mdio_o, .mdio_oe, .int_pin, .indicator_a, .indicator_b, .link_up, .link_speed,
    .link_activity, .core_rx_dv, .core_rxd, .core_rx_er(core_rx_dv), .core_crs, .core_col(core_crs), .int_event,
    .core_tx_strobe, .core_tx_en, .core_txd, .core_tx_er, .host_mode_active);
  phi_mac_model i_mac (.run, .nibble(link_speed != SPD_1000), .tx_clk, .gtx_clk, .tx_en, .txd, .tx_er);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic rst(input logic [3:0] mode, input logic st);
    @(negedge clk);
    resetn = 1'b0;
    host_mode_strap = mode;
    indicator_style_strap = st;
    ref_clock_out_strap = mode[0];
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  task automatic mframe(input logic [1:0] op, input logic [4:0] ph, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic [16:0] s;
    f = {32'hffff_ffff, 2'b01, op, ph, rg, (op == OP_READ) ? 2'b11 : 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      @(negedge clk);
      mdc = 1'b0;
      host_oe = !(op == OP_READ && i < 18);
      host_d = f[i];
      repeat (3) @(negedge clk);
      if (i < 17) s[i] = mdio_i;
      mdc = 1'b1;
      repeat (3) @(negedge clk);
    end
    @(negedge clk);
    mdc = 1'b0;
    host_oe = 1'b0;
    repeat (8) @(negedge clk);
    rd = s[15:0];
    if (op == OP_READ && ph == ME) `CHK(s[16], 1'b0)
    `CHK(mdio_oe, 1'b0)
  endtask

  task automatic rchk(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] exp);
    logic [15:0] r;
    mframe(OP_READ, ph, rg, 16'h0000, r);
    `CHK(r, exp)
  endtask

  task automatic pulse(input logic [7:0] e);
    @(negedge clk);
    int_event = e;
    @(negedge clk);
    int_event = 8'h00;
    repeat (3) @(negedge clk);
  endtask

  task automatic blink;
    logic p;
    n = 0;
    p = indicator_a;
    repeat (40) begin
      @(negedge clk);
      n += int'(indicator_a != p);
      p = indicator_a;
    end
    `CHK(n >= 4, 1'b1)
  endtask

  task automatic txchk(input logic [7:0] m);
    logic [7:0] p;
    int k;
    k = 0;
    p = 8'h00;
    repeat (400) begin
      @(negedge clk);
      if (core_tx_strobe) begin
        if (k > 0) `CHK({core_tx_en, core_tx_er, core_txd & m}, {2'b10, (p + 8'h01) & m})
        p = core_txd;
        k++;
      end
    end
    `CHK(k > 3, 1'b1)
  endtask

  task automatic finish_test;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    num_errors++;
    finish_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {resetn, mdc, host_oe, host_d, run, link_up, link_activity, core_rx_dv, core_crs} = '0;
    {int_event, core_rxd, link_speed, host_mode_strap, ref_clock_out_strap, indicator_style_strap} = '0;
    rst(MODE_GMII_MII, 1'b1);
    `CHK(host_mode_active, 1'b1)
    `CHK(int_pin, 1'b1)
    b = ref_clock_out;
    @(negedge clk);
    `CHK(ref_clock_out, ~b)
    rchk(ME, REG_INT_EN_STAT, INT_EN_STAT_RST);
    rchk(ME, REG_MISC_CTRL, MISC_CTRL_RST);
    mframe(OP_WRITE, ME, REG_MISC_CTRL, 16'hbeef, v);
    rchk(ME, REG_MISC_CTRL, 16'hbeef);
    mframe(OP_WRITE, 5'h00, REG_MISC_CTRL, 16'h0000, v);
    mframe(2'b00, ME, REG_MISC_CTRL, 16'h0000, v);
    rchk(ME, REG_MISC_CTRL, 16'hbeef);
    rchk(5'h00, REG_MISC_CTRL, 16'hffff);
    rchk(5'h0d, REG_MISC_CTRL, 16'hffff);
    rchk(ME, 5'h02, 16'h0000);
    mframe(OP_WRITE, ME, REG_INT_EN_STAT, 16'h0400, v);
    pulse(8'h01);
    `CHK(int_pin, 1'b1)
    rchk(ME, REG_INT_EN_STAT, 16'h0401);
    rchk(ME, REG_INT_EN_STAT, 16'h0400);
    pulse(8'h04);
    `CHK(int_pin, 1'b0)
    rchk(ME, REG_INT_EN_STAT, 16'h0404);
    `CHK(int_pin, 1'b1)
    mframe(OP_WRITE, ME, REG_MISC_CTRL, 16'h4000, v);
    `CHK(int_pin, 1'b0)
    pulse(8'h04);
    `CHK(int_pin, 1'b1)
    link_up = 1'b1;
    link_speed = SPD_100;
    core_rx_dv = 1'b1;
    core_rxd = 8'h3c;
    core_crs = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({rx_er, rx_dv, rxd}, 10'h30c)
    `CHK({crs, col, indicator_b, indicator_a}, 4'hd)
    link_activity = 1'b1;
    blink();
    link_speed = SPD_1000;
    repeat (4) @(negedge clk);
    `CHK(rxd, 8'h3c)
    run = 1'b1;
    txchk(8'hff);
    run = 1'b0;
    repeat (8) @(negedge clk);
    link_speed = SPD_10;
    run = 1'b1;
    txchk(8'h0f);
    run = 1'b0;
    link_activity = 1'b0;
    rst(MODE_GMII_MII, 1'b0);
    link_speed = SPD_1000;
    repeat (3) @(negedge clk);
    `CHK({indicator_a, indicator_b}, 2'b10)
    link_speed = SPD_100;
    repeat (3) @(negedge clk);
    `CHK({indicator_a, indicator_b}, 2'b01)
    link_speed = SPD_10;
    repeat (3) @(negedge clk);
    `CHK({indicator_a, indicator_b}, 2'b00)
    link_activity = 1'b1;
    blink();
    link_up = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({indicator_a, indicator_b}, 2'b11)
    rst(4'h4, 1'b1);
    `CHK({host_mode_active, ref_clock_out}, 2'b00)
    finish_test();
  end
endmodule // phi_host_if_tb

`default_nettype wire
